// ---- quad_dac_consts.svh ----
// constants of the quad converter serial front end
// assumes 32-bit avalon data and byte addresses on a 6-bit address bus
`ifndef QUAD_DAC_CONSTS_SVH
`define QUAD_DAC_CONSTS_SVH

// register byte offsets; code window base in address bits 5:4
`define QD_CTRL_OFS      6'h00
`define QD_STATUS_OFS    6'h04
`define QD_COUNT_OFS     6'h08
`define QD_WORD_OFS      6'h0c
`define QD_CODE_BASE     2'h1
// control fields and reset value
`define QD_CTRL_EN_BIT   0
`define QD_CTRL_RESET    1'b1
// status fields
`define QD_ST_FRAME_BIT  0
`define QD_ST_STRAP_BIT  1
`define QD_ST_ADDR_LSB   8
`define QD_ST_PD_LSB     16
// fixed global slave address
`define QD_GLOBAL_ADDR   7'h73
// command nibble codes
`define QD_CMD_WRITE     4'h0
`define QD_CMD_UPDATE    4'h1
`define QD_CMD_WR_UPD_ALL 4'h2
`define QD_CMD_WR_UPD    4'h3
`define QD_CMD_PWR_DOWN  4'h4
`define QD_SEL_ALL       4'hf
// strap settle cycles per drive phase
`define QD_STRAP_SETTLE  4'h8
// bit count at which a byte is complete
`define QD_BITS_PER_BYTE 4'h8

`endif

// ---- quad_dac_pkg.sv ----
// types of the quad converter serial front end
// assumes quad_dac_consts.svh holds the register, command and strap constants
package quad_dac_pkg;

	typedef enum logic [2:0] {
		FR_IDLE  = 3'b000,
		FR_ADDR  = 3'b001,
		FR_DATA0 = 3'b010,
		FR_DATA1 = 3'b011,
		FR_DATA2 = 3'b100,
		FR_SKIP  = 3'b101
	} frame_state_t;

	typedef enum logic [1:0] {
		ST_HI   = 2'b00,
		ST_LO   = 2'b01,
		ST_DONE = 2'b10
	} strap_state_t;

endpackage : quad_dac_pkg

// ---- i2c_rx_if.sv ----
// carrier between the bit receiver and the frame controller
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface i2c_rx_if;
	logic       start_det;
	logic       stop_det;
	logic       byte_done;
	logic [7:0] byte_data;
	logic       ack_req;

	modport rx  (output start_det, stop_det, byte_done, byte_data,
		input ack_req);
	modport ctl (input start_det, stop_det, byte_done, byte_data,
		output ack_req);
endinterface : i2c_rx_if
`default_nettype wire

// ---- i2c_bit_receiver.sv ----
// two-wire bit receiver: synchronises the lines, finds start and stop,
// shifts bytes in and drives the acknowledge low when asked
// assumes scl and sda arrive asynchronously to clk_i
`timescale 1ns/1ps
`default_nettype none
`include "quad_dac_consts.svh"
module i2c_bit_receiver (
	input  wire logic clk_i,    // system clock
	input  wire logic rst_i,    // synchronous reset, high
	input  wire logic scl_i,    // serial clock pin level
	input  wire logic sda_i,    // serial data pin level
	output logic      sda_oe_o, // pull data low while high
	i2c_rx_if.rx      rx        // byte events to controller
);
	logic [1:0] scl_s_r;
	logic [1:0] sda_s_r;
	logic       scl_q_r;
	logic       sda_q_r;
	logic       active_r;
	logic [3:0] bitcnt_r;
	logic       ack_phase_r;
	logic [7:0] shift_r;
	logic       done_r;
	logic       oe_r;
	logic       scl_rise;
	logic       scl_fall;
	logic       start;
	logic       stop;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[0], scl_i};
			sda_s_r <= {sda_s_r[0], sda_i};
			scl_q_r <= scl_s_r[1];
			sda_q_r <= sda_s_r[1];
		end
	end

	assign scl_rise = scl_s_r[1] & ~scl_q_r;
	assign scl_fall = ~scl_s_r[1] & scl_q_r;
	assign start = scl_s_r[1] & scl_q_r & sda_q_r & ~sda_s_r[1];
	assign stop  = scl_s_r[1] & scl_q_r & ~sda_q_r & sda_s_r[1];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_r    <= 1'b0;
			bitcnt_r    <= 4'h0;
			ack_phase_r <= 1'b0;
			shift_r     <= 8'h00;
			done_r      <= 1'b0;
			oe_r        <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (start) begin
				active_r    <= 1'b1;
				bitcnt_r    <= 4'h0;
				ack_phase_r <= 1'b0;
				oe_r        <= 1'b0;
			end else if (stop) begin
				active_r    <= 1'b0;
				bitcnt_r    <= 4'h0;
				ack_phase_r <= 1'b0;
				oe_r        <= 1'b0;
			end else if (active_r) begin
				if (scl_rise && bitcnt_r < `QD_BITS_PER_BYTE) begin
					shift_r  <= {shift_r[6:0], sda_s_r[1]};
					bitcnt_r <= bitcnt_r + 4'h1;
					if (bitcnt_r == `QD_BITS_PER_BYTE - 4'h1) begin
						done_r <= 1'b1;
					end
				end
				if (scl_fall && bitcnt_r == `QD_BITS_PER_BYTE) begin
					if (!ack_phase_r) begin
						ack_phase_r <= 1'b1;
						oe_r        <= rx.ack_req;
					end else begin
						ack_phase_r <= 1'b0;
						oe_r        <= 1'b0;
						bitcnt_r    <= 4'h0;
					end
				end
			end
		end
	end

	assign sda_oe_o     = oe_r;
	assign rx.start_det = start;
	assign rx.stop_det  = stop;
	assign rx.byte_done = done_r;
	assign rx.byte_data = shift_r;
endmodule : i2c_bit_receiver
`default_nettype wire

// ---- quad_dac_i2c_slave_front_end.sv ----
// write-only two-wire slave front end of a quad converter
// assumes async serial pins, three-state straps, avalon master on clk_i
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "quad_dac_consts.svh"
module quad_dac_i2c_slave_front_end #(
	parameter int RES_BITS = 16, // 16, 14 or 12
	parameter bit MIDSCALE = 0   // reset to midscale when set
) (
	input  wire logic        clk_i,           // 10 MHz system clock
	input  wire logic        rst_i,           // synchronous reset
	input  wire logic [5:0]  address_i,       // avalon byte address
	input  wire logic        read_i,          // avalon read
	input  wire logic        write_i,         // avalon write
	input  wire logic [31:0] writedata_i,     // avalon write data
	output logic [31:0]      readdata_o,      // avalon read data
	output logic             waitrequest_o,   // avalon wait
	input  wire logic        scl_i,           // serial clock pin
	input  wire logic        sda_i,           // serial data pin level
	output logic             sda_o,           // data drive value, low
	output logic             sda_oe_o,        // data pull-down enable
	input  wire logic [2:0]  address_strap_i, // strap pin levels
	output logic [2:0]       address_strap_o, // strap test drive
	output logic [2:0]       address_strap_oe_o, // strap drive enable
	output logic [3:0][15:0] channel_code_o,  // active codes a..d
	output logic [3:0]       power_down_o     // channel powered down
);
	localparam logic [15:0] RESET_CODE = MIDSCALE ?
		16'(32'h1 << (RES_BITS - 1)) : 16'h0000;

	i2c_rx_if rxb ();

	quad_dac_pkg::frame_state_t fr_r;
	quad_dac_pkg::strap_state_t ss_r;
	logic [2:0]       strap_s1_r;
	logic [2:0]       strap_s2_r;
	logic [3:0]       settle_r;
	logic [2:0]       hi_seen_r;
	logic [2:0]       lo_seen_r;
	logic [4:0]       strap_idx;
	logic [6:0]       slave_addr;
	logic             addr_match;
	logic             ack_r;
	logic [7:0]       cmd_byte_r;
	logic [7:0]       hi_byte_r;
	logic             exec_r;
	logic [15:0]      word_r;
	logic [15:0]      code_in;
	logic [3:0]       cmd;
	logic [3:0]       sel_mask;
	logic             ctrl_en_r;
	logic [15:0]      count_r;
	logic             resp_r;
	logic [31:0]      rdata_r;
	logic [3:0][15:0] input_r;
	logic [3:0][15:0] active_r;
	logic [3:0]       pd_r;

	i2c_bit_receiver u_rx (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.scl_i    (scl_i),
		.sda_i    (sda_i),
		.sda_oe_o (sda_oe_o),
		.rx       (rxb)
	);

	// strap level: float follows the test drive, tied pins do not
	function automatic logic [1:0] strap_level(input logic hi,
		input logic lo);
		strap_level = (hi & ~lo) ? 2'h1 : (hi ? 2'h2 : 2'h0);
	endfunction : strap_level

	// select nibble to channel mask
	function automatic logic [3:0] chan_mask(input logic [3:0] sel);
		case (sel)
			4'h0:        chan_mask = 4'h1;
			4'h1:        chan_mask = 4'h2;
			4'h2:        chan_mask = 4'h4;
			4'h3:        chan_mask = 4'h8;
			`QD_SEL_ALL: chan_mask = 4'hf;
			default:     chan_mask = 4'h0;
		endcase
	endfunction : chan_mask

	// strap sync
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_s1_r <= 3'h0;
			strap_s2_r <= 3'h0;
		end else begin
			strap_s1_r <= address_strap_i;
			strap_s2_r <= strap_s1_r;
		end
	end

	// drive straps high then low and watch which follow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ss_r      <= quad_dac_pkg::ST_HI;
			settle_r  <= 4'h0;
			hi_seen_r <= 3'h0;
			lo_seen_r <= 3'h0;
		end else begin
			case (ss_r)
				quad_dac_pkg::ST_HI: begin
					settle_r <= settle_r + 4'h1;
					if (settle_r == `QD_STRAP_SETTLE - 4'h1) begin
						hi_seen_r <= strap_s2_r;
						settle_r  <= 4'h0;
						ss_r      <= quad_dac_pkg::ST_LO;
					end
				end
				quad_dac_pkg::ST_LO: begin
					settle_r <= settle_r + 4'h1;
					if (settle_r == `QD_STRAP_SETTLE - 4'h1) begin
						lo_seen_r <= strap_s2_r;
						settle_r  <= 4'h0;
						ss_r      <= quad_dac_pkg::ST_DONE;
					end
				end
				quad_dac_pkg::ST_DONE: begin
					settle_r <= 4'h0;
				end
				default: begin
					ss_r <= quad_dac_pkg::ST_HI;
				end
			endcase
		end
	end

	assign address_strap_oe_o = (ss_r == quad_dac_pkg::ST_DONE) ?
		3'h0 : 3'h7;
	assign address_strap_o = (ss_r == quad_dac_pkg::ST_HI) ? 3'h7 : 3'h0;

	assign strap_idx =
		5'(strap_level(hi_seen_r[2], lo_seen_r[2])) * 5'd9 +
		5'(strap_level(hi_seen_r[1], lo_seen_r[1])) * 5'd3 +
		5'(strap_level(hi_seen_r[0], lo_seen_r[0]));
	assign slave_addr = {strap_idx[4:2] + 3'h1, 2'b00, strap_idx[1:0]};

	assign addr_match = (ss_r == quad_dac_pkg::ST_DONE) && ctrl_en_r &&
		!rxb.byte_data[0] &&
		(rxb.byte_data[7:1] == slave_addr ||
		rxb.byte_data[7:1] == `QD_GLOBAL_ADDR);

	// frame sequencing and acknowledge decision
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fr_r   <= quad_dac_pkg::FR_IDLE;
			ack_r  <= 1'b0;
			exec_r <= 1'b0;
		end else begin
			exec_r <= 1'b0;
			if (rxb.start_det) begin
				fr_r  <= quad_dac_pkg::FR_ADDR;
				ack_r <= 1'b0;
			end else if (rxb.stop_det) begin
				fr_r  <= quad_dac_pkg::FR_IDLE;
				ack_r <= 1'b0;
			end else if (rxb.byte_done) begin
				case (fr_r)
					quad_dac_pkg::FR_ADDR: begin
						fr_r  <= addr_match ? quad_dac_pkg::FR_DATA0 :
							quad_dac_pkg::FR_SKIP;
						ack_r <= addr_match;
					end
					quad_dac_pkg::FR_DATA0: begin
						fr_r  <= quad_dac_pkg::FR_DATA1;
						ack_r <= 1'b1;
					end
					quad_dac_pkg::FR_DATA1: begin
						fr_r  <= quad_dac_pkg::FR_DATA2;
						ack_r <= 1'b1;
					end
					quad_dac_pkg::FR_DATA2: begin
						fr_r   <= quad_dac_pkg::FR_SKIP;
						ack_r  <= 1'b1;
						exec_r <= 1'b1;
					end
					default: begin
						ack_r <= 1'b0;
					end
				endcase
			end
		end
	end

	assign rxb.ack_req = ack_r;
	assign sda_o = 1'b0;

	// data byte capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_byte_r <= 8'h00;
			hi_byte_r  <= 8'h00;
			word_r     <= 16'h0000;
		end else if (rxb.byte_done) begin
			if (fr_r == quad_dac_pkg::FR_DATA0) begin
				cmd_byte_r <= rxb.byte_data;
			end
			if (fr_r == quad_dac_pkg::FR_DATA1) begin
				hi_byte_r <= rxb.byte_data;
			end
			if (fr_r == quad_dac_pkg::FR_DATA2) begin
				word_r <= {hi_byte_r, rxb.byte_data};
			end
		end
	end

	assign cmd      = cmd_byte_r[7:4];
	assign sel_mask = chan_mask(cmd_byte_r[3:0]);
	assign code_in  = word_r >> (16 - RES_BITS);

	// per-channel input, active code and power state
	generate
		for (genvar n = 0; n < 4; n++) begin : g_chan
			logic wr;
			logic upd;
			logic pd;
			assign wr = exec_r && sel_mask[n] && (cmd == `QD_CMD_WRITE ||
				cmd == `QD_CMD_WR_UPD_ALL || cmd == `QD_CMD_WR_UPD);
			assign upd = exec_r && ((sel_mask[n] &&
				(cmd == `QD_CMD_UPDATE || cmd == `QD_CMD_WR_UPD)) ||
				cmd == `QD_CMD_WR_UPD_ALL);
			assign pd = exec_r && sel_mask[n] && cmd == `QD_CMD_PWR_DOWN;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					input_r[n]  <= RESET_CODE;
					active_r[n] <= RESET_CODE;
					pd_r[n]     <= 1'b0;
				end else begin
					if (wr) begin
						input_r[n] <= code_in;
					end
					if (upd) begin
						active_r[n] <= wr ? code_in : input_r[n];
						pd_r[n]     <= 1'b0;
					end else if (pd) begin
						pd_r[n] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// k over 2^N of span: code handed on right aligned
	assign channel_code_o = active_r;
	assign power_down_o   = pd_r;

	// executed command counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= 16'h0000;
		end else if (exec_r) begin
			count_r <= count_r + 16'h0001;
		end
	end

	// avalon slave: one wait state per access
	assign waitrequest_o = (read_i | write_i) & ~resp_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resp_r <= 1'b0;
		end else begin
			resp_r <= (read_i | write_i) & ~resp_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_en_r <= `QD_CTRL_RESET;
		end else if (write_i && resp_r && address_i == `QD_CTRL_OFS) begin
			ctrl_en_r <= writedata_i[`QD_CTRL_EN_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (read_i && !resp_r) begin
			rdata_r <= 32'h0000_0000;
			if (address_i[5:4] == `QD_CODE_BASE) begin
				rdata_r[15:0] <= active_r[address_i[3:2]];
			end else begin
				case (address_i)
					`QD_CTRL_OFS: rdata_r[`QD_CTRL_EN_BIT] <= ctrl_en_r;
					`QD_STATUS_OFS: begin
						rdata_r[`QD_ST_FRAME_BIT] <=
							fr_r != quad_dac_pkg::FR_IDLE;
						rdata_r[`QD_ST_STRAP_BIT] <=
							ss_r == quad_dac_pkg::ST_DONE;
						rdata_r[`QD_ST_ADDR_LSB +: 7] <= slave_addr;
						rdata_r[`QD_ST_PD_LSB +: 4]   <= pd_r;
					end
					`QD_COUNT_OFS: rdata_r[15:0] <= count_r;
					`QD_WORD_OFS:  rdata_r[23:0] <= {cmd_byte_r, word_r};
					default:       rdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign readdata_o = rdata_r;
endmodule : quad_dac_i2c_slave_front_end
`default_nettype wire

// ---- quad_dac_front_end_sva.sv ----
// port checker of the quad converter serial front end
// assumes a bind to the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module quad_dac_front_end_sva #(
	parameter int RES_BITS = 16, // code width
	parameter bit MIDSCALE = 0   // midscale reset
) (
	input wire logic             clk_i,              // clock
	input wire logic             rst_i,              // reset
	input wire logic [5:0]       address_i,          // bus address
	input wire logic             read_i,             // bus read
	input wire logic             write_i,            // bus write
	input wire logic [31:0]      readdata_o,         // read data
	input wire logic             waitrequest_o,      // bus wait
	input wire logic             scl_i,              // serial clock
	input wire logic             sda_o,              // drive value
	input wire logic             sda_oe_o,           // pull-down
	input wire logic [2:0]       address_strap_o,    // strap drive
	input wire logic [2:0]       address_strap_oe_o, // strap enable
	input wire logic [3:0][15:0] channel_code_o,     // active codes
	input wire logic [3:0]       power_down_o        // power down
);
	localparam logic [15:0] RST_CODE =
		MIDSCALE ? 16'h1 << (RES_BITS - 1) : 16'h0;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_open_drain: assert property (sda_oe_o |-> !sda_o)
		else $error("data line driven high");
	a_ack_hold: assert property (scl_i && sda_oe_o |=> sda_oe_o)
		else $error("ack dropped while clock high");
	a_ack_start: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("ack began while clock high");
	a_ack_len: assert property ($rose(sda_oe_o) |->
		sda_oe_o [*7] ##[1:3] !sda_oe_o)
		else $error("ack length wrong");
	a_reset_code: assert property ($fell(rst_i) |->
		channel_code_o == {4{RST_CODE}} && power_down_o == 4'h0)
		else $error("reset codes wrong");
	a_strap_init: assert property ($fell(rst_i) |->
		address_strap_oe_o == 3'h7 && address_strap_o == 3'h7)
		else $error("strap test not driving high");
	a_strap_done: assert property (address_strap_oe_o == 3'h0 |=>
		address_strap_oe_o == 3'h0)
		else $error("strap drive resumed");
	a_early_ack: assert property (address_strap_oe_o != 3'h0 |->
		!sda_oe_o)
		else $error("ack before straps resolved");
	a_wait_one: assert property ($rose(read_i || write_i) |->
		waitrequest_o ##1 !waitrequest_o)
		else $error("bus wait not one cycle");
	a_unmapped_zero: assert property (read_i && !waitrequest_o &&
		address_i == 6'h3c |-> readdata_o == 32'h0)
		else $error("unmapped read not zero");
endmodule : quad_dac_front_end_sva
bind quad_dac_i2c_slave_front_end quad_dac_front_end_sva #(
	.RES_BITS(RES_BITS), .MIDSCALE(MIDSCALE)) u_sva (.clk_i, .rst_i,
	.address_i, .read_i, .write_i, .readdata_o, .waitrequest_o, .scl_i,
	.sda_o, .sda_oe_o, .address_strap_o, .address_strap_oe_o,
	.channel_code_o, .power_down_o);
`default_nettype wire

// ---- i2c_master_model.sv ----
// serial bus master model: frames, bytes msb first, ack sampling
// assumes clk_i at 10 MHz; clock period 8 cycles, low 6, high 2
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	input  wire logic clk_i, // pacing clock
	input  wire logic sda_i, // resolved data line
	output logic      scl_o, // serial clock
	output logic      sda_o  // data drive, 1 releases
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	// also serves as repeated start
	task automatic start();
		tick(6);
		sda_o <= 1'b1;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		sda_o <= 1'b0;
		tick(4);
		scl_o <= 1'b0;
	endtask : start
	task automatic stop();
		tick(1);
		sda_o <= 1'b0;
		tick(6);
		scl_o <= 1'b1;
		tick(4);
		sda_o <= 1'b1;
		tick(12);
	endtask : stop
	// one pulse; line level taken at end of high phase
	task automatic pulse(input logic b, output logic r);
		tick(1);
		sda_o <= b;
		tick(5);
		scl_o <= 1'b1;
		tick(2);
		r = sda_i;
		scl_o <= 1'b0;
	endtask : pulse
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			pulse(d[i], r);
		pulse(1'b1, r);
		ack = ~r;
	endtask : send
endmodule : i2c_master_model
`default_nettype wire

// ---- quad_dac_i2c_slave_front_end_bench.sv ----
// bench of the quad converter front end: frames, straps, avalon
// assumes i2c_master_model drives the serial lines
`timescale 1ns/1ps
`default_nettype none
module quad_dac_i2c_slave_front_end_bench;
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic [5:0]       address_i = 6'h00;
	logic             read_i = 1'b0;
	logic             write_i = 1'b0;
	logic [31:0]      writedata_i = 32'h0;
	logic [31:0]      readdata_o;
	logic [31:0]      q;
	logic             waitrequest_o;
	logic             sda_o;
	logic             sda_oe_o;
	logic             scl;
	logic             sda_m;
	logic             sda;
	logic [2:0]       strap;
	logic [2:0]       strap_o;
	logic [2:0]       strap_oe;
	logic [3:0][15:0] code;
	logic [3:0]       pd;
	logic             sda_o2;
	logic             sda_oe2;
	logic [3:0][15:0] code2;
	int               n_errors = 0;
	int               samples_checked = 0;
	int               cyc = 0;
	always #50 clk_i = ~clk_i;
	// open-drain data line with pull-up
	assign sda = sda_oe_o ? sda_o : (sda_oe2 ? sda_o2 : sda_m);
	// strap 2 floats, 1 tied high, 0 tied low: address 7'h43
	assign strap = {strap_oe[2] ? strap_o[2] : cyc[0], 2'b10};
	quad_dac_i2c_slave_front_end dut (.clk_i, .rst_i, .address_i,
		.read_i, .write_i, .writedata_i, .readdata_o, .waitrequest_o,
		.scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o,
		.address_strap_i(strap), .address_strap_o(strap_o),
		.address_strap_oe_o(strap_oe), .channel_code_o(code),
		.power_down_o(pd));
	i2c_master_model mst (.clk_i, .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
	// second build on the same lines: midscale, 12 bits, straps tied low
	quad_dac_i2c_slave_front_end #(.RES_BITS(12), .MIDSCALE(1'b1)) dut2 (
		.clk_i, .rst_i, .address_i(6'h00), .read_i(1'b0),
		.write_i(1'b0), .writedata_i(32'h0), .readdata_o(),
		.waitrequest_o(), .scl_i(scl), .sda_i(sda), .sda_o(sda_o2),
		.sda_oe_o(sda_oe2), .address_strap_i(3'h0),
		.address_strap_o(), .address_strap_oe_o(),
		.channel_code_o(code2), .power_down_o());
	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		read_i <= ~wr;
		write_i <= wr;
		address_i <= a;
		writedata_i <= d;
		do @(posedge clk_i); while (waitrequest_o !== 1'b0);
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask : bus
	// address byte, n data bytes (fourth is surplus), stop; acks judged
	task automatic frame(input logic [7:0] a, input logic [23:0] w,
		input int n, input logic [4:0] exp);
		logic [31:0] b;
		logic [4:0]  ak;
		logic        r;
		b = {w, 8'h55};
		ak = 5'h0;
		mst.start();
		mst.send(a, r);
		ak[0] = r;
		for (int i = 0; i < n; i++) begin
			mst.send(b[31-8*i -: 8], r);
			ak[i+1] = r;
		end
		mst.stop();
		chk(ak, exp);
	endtask : frame
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk(code, 64'h0);
		chk(pd, 4'h0);
		chk(code2, {4{16'h0800}});
		bus(1'b0, 6'h04, 32'h0);
		chk(q[14:8], 7'h43);
		bus(1'b0, 6'h3c, 32'h0);
		chk(q, 32'h0);
		frame(8'h86, 24'h31_1234, 3, 5'h0f);
		chk(code, 64'h0000_0000_1234_0000);
		frame(8'he6, 24'h3f_abcd, 4, 5'h0f);
		chk(code, {4{16'habcd}});
		chk(code2, {4{16'h0abc}});
		frame(8'h20, 24'h33_fff0, 3, 5'h0f);
		chk(code2, 64'h0fff_0abc_0abc_0abc);
		frame(8'h87, 24'h3f_0000, 0, 5'h00);
		frame(8'h86, 24'h02_5555, 3, 5'h0f);
		chk(code, {4{16'habcd}});
		frame(8'h86, 24'h12_0000, 3, 5'h0f);
		chk(code, 64'habcd_5555_abcd_abcd);
		frame(8'h86, 24'h43_0000, 3, 5'h0f);
		chk(pd, 4'h8);
		frame(8'h86, 24'h20_0001, 3, 5'h0f);
		chk(pd, 4'h0);
		frame(8'h86, 24'h3f_9999, 2, 5'h07);
		frame(8'h86, 24'hff_9999, 3, 5'h0f);
		chk(code, 64'habcd_5555_abcd_0001);
		bus(1'b1, 6'h00, 32'h0);
		frame(8'h86, 24'h3f_9999, 0, 5'h00);
		bus(1'b1, 6'h00, 32'h1);
		bus(1'b0, 6'h14, 32'h0);
		chk(q, 32'h0000_abcd);
		bus(1'b0, 6'h08, 32'h0);
		chk(q, 32'h0000_0007);
		finish_test();
	end
endmodule : quad_dac_i2c_slave_front_end_bench
`default_nettype wire
